// [design/bau_unit.sv]
// Purpose: accumulator and flags around the add-subtract adder
// Assumes: sequencer issues one op per strobe; operand valid with it
// Notes: results commit on the strobe's edge, one cycle later visible
`timescale 1ns/1ps
`include "bau_consts.svh"

// Contract
// RULE_01 - decimal mode yields corrected packed bcd sum, no adjust step
// RULE_02 - dedicated decimal flag flop picks binary or decimal adder
// RULE_03 - decimal mode persists until software changes the flag
// RULE_04 - add: accumulator plus operand plus carry into accumulator
// RULE_05 - add carry is ninth bit, set above 255 or 99
// RULE_06 - subtract: accumulator minus operand minus inverted carry
// RULE_07 - borrow is the inverse of the carry flag
// RULE_08 - subtract sets carry when result not negative
// RULE_09 - subtract sets overflow when signed result out of range
// RULE_10 - negative flag copies result bit 7 after subtract
// RULE_11 - zero flag set when subtract result is zero
// RULE_12 - subtract accepts all eight addressing modes
// RULE_13 - subtract feeds complemented operand plus carry to same adder
// RULE_14 - complement and add form one combined operation
// RULE_15 - byte carry kept and used by next higher byte
// RULE_16 - ops exist to set carry, clear carry, set decimal
// RULE_17 - software sets carry before subtract, clears before add
// RULE_18 - decimal subtract gives bcd difference; clear carry is borrow
// RULE_19 - add overflow when sign of result wrong for operands
// RULE_20 - decimal digits corrected by six with digit carry
// RULE_21 - negative and zero follow add result as well
// RULE_22 - all updates of one instruction commit together
module bau_unit
  import bau_pkg::*;
#(
  parameter int DATA_W = `BAU_DATA_W
)
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  // instruction from sequencer
  input  wire logic              i_op_valid,
  input  bau_op_type             i_op,
  input  bau_amode_type          i_amode,
  input  wire logic [DATA_W-1:0] i_operand,
  // accumulator and flags
  output logic      [DATA_W-1:0] o_acc,
  output bau_flags_type          o_flags,
  output logic                   o_done,
  output logic                   o_bad_mode
);
  // elaboration check; the digit split is fixed at two nibbles
  if (DATA_W != 8)
  begin : g_bad_width
    $error("bau_unit serves only 8-bit data");
  end

  bau_state_type st_q;
  bau_state_type st_d;
  bau_res_type   res;
  logic          is_sub;

  // valid addressing mode check; all eight encodings are legal
  function automatic logic amode_ok(input bau_amode_type m);
    unique case (m)
      BAU_AM_IMM, BAU_AM_ABS, BAU_AM_ZP, BAU_AM_ABS_X,
      BAU_AM_ABS_Y, BAU_AM_ZP_X, BAU_AM_IND_X, BAU_AM_IND_Y: amode_ok = 1'b1;
      default: amode_ok = 1'b0;
    endcase
  endfunction

  // ops that run the adder and rewrite the arithmetic flags
  function automatic logic is_arith(input bau_op_type op);
    return (op == BAU_OP_ADD) || (op == BAU_OP_SUB);
  endfunction

  // both digits of a byte are legal decimal digits
  function automatic logic is_bcd(input logic [7:0] m);
    return (m[7:4] <= `BAU_DIGIT_MAX) && (m[3:0] <= `BAU_DIGIT_MAX);
  endfunction

  // decimal worth of a packed two-digit byte, 0 to 99 when legal
  function automatic logic [7:0] dec_val(input logic [7:0] m);
    return 8'(m[7:4]) * 8'h0a + 8'(m[3:0]);
  endfunction

  assign is_sub = (i_op == BAU_OP_SUB);

  // shared adder; carry flag is the carry-in for both directions
  // RULE_07 carry in, borrow inverted
  bau_adder #(
    .DATA_W (DATA_W)
  ) u_adder (
    .i_a       (st_q.acc),
    .i_m       (i_operand),
    .i_carry   (st_q.flags.carry),
    .i_sub     (is_sub),
    .i_decimal (st_q.flags.decimal),
    .o_res     (res)
  );

  // next state; flags and accumulator change in one edge
  always_comb
  begin
    st_d          = st_q;
    st_d.done     = 1'b0;
    st_d.bad_mode = 1'b0;
    if (i_op_valid)
    begin
      st_d.done = 1'b1;
      unique case (i_op)
        BAU_OP_NONE:
        begin
          st_d.done = 1'b0;
        end
        BAU_OP_ADD, BAU_OP_SUB:
        begin
          // RULE_12 every addressing mode accepted
          if (!amode_ok(i_amode))
            st_d.bad_mode = 1'b1;
          // RULE_04 result to accumulator
          // RULE_06 subtract through same path
          // RULE_01 corrected sum stored directly
          st_d.acc         = res.sum;
          // RULE_08 carry clear means borrow
          // RULE_15 carry kept for next byte
          st_d.flags.carry = res.carry;
          st_d.flags.ovf   = res.ovf;
          // RULE_10 sign from bit 7
          // RULE_21 same on add
          st_d.flags.neg   = res.sum[`BAU_SIGN_BIT];
          // RULE_11 zero detect
          st_d.flags.zero  = (res.sum == '0);
        end
        // RULE_16 carry and decimal control ops
        BAU_OP_SET_CARRY:   st_d.flags.carry   = 1'b1;
        BAU_OP_CLEAR_CARRY: st_d.flags.carry   = 1'b0;
        // RULE_02 decimal flag flop
        BAU_OP_SET_DEC:     st_d.flags.decimal = 1'b1;
        BAU_OP_CLEAR_DEC:   st_d.flags.decimal = 1'b0;
        BAU_OP_LOAD:
        begin
          // accumulator load so a byte chain can be started
          st_d.acc        = i_operand;
          st_d.flags.neg  = i_operand[`BAU_SIGN_BIT];
          st_d.flags.zero = (i_operand == '0);
        end
        default:
        begin
          st_d.done = 1'b0;
        end
      endcase
    end
  end

  // single state register
  // RULE_22 one commit edge
  // RULE_03 decimal only changes by its own ops
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      st_q.acc           <= `BAU_RST_ACC;
      st_q.flags.carry   <= `BAU_RST_CARRY;
      st_q.flags.decimal <= `BAU_RST_DEC;
      st_q.flags.ovf     <= `BAU_RST_OVF;
      st_q.flags.neg     <= `BAU_RST_NEG;
      st_q.flags.zero    <= `BAU_RST_ZERO;
      st_q.done          <= 1'b0;
      st_q.bad_mode      <= 1'b0;
    end
    else
      st_q <= st_d;
  end

  // outputs straight from the state flops
  assign o_acc      = st_q.acc;
  assign o_flags    = st_q.flags;
  assign o_done     = st_q.done;
  assign o_bad_mode = st_q.bad_mode;

  // checks
  AST_ADD_BIN: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_04
    (i_op_valid && i_op == BAU_OP_ADD && !o_flags.decimal) |=>
      ({o_flags.carry, o_acc} == 9'($past(o_acc)) + 9'($past(i_operand)) + 9'($past(o_flags.carry))))
    else $error("binary add result wrong");
  AST_SUB_BIN: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_06
    (i_op_valid && i_op == BAU_OP_SUB && !o_flags.decimal) |=>
      (o_acc == 8'($past(o_acc) - $past(i_operand) - 8'(!$past(o_flags.carry)))))
    else $error("binary subtract result wrong");
  AST_SUB_CARRY: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_08
    (i_op_valid && i_op == BAU_OP_SUB && !o_flags.decimal) |=>
      (o_flags.carry == ({1'b0, $past(o_acc)} >= {1'b0, $past(i_operand)} + 9'(!$past(o_flags.carry)))))
    else $error("subtract carry wrong");
  AST_NEG_FLAG: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_10
    $past(i_op_valid && (i_op == BAU_OP_ADD || i_op == BAU_OP_SUB)) |-> (o_flags.neg == o_acc[7]))
    else $error("negative flag does not follow bit 7");
  AST_ZERO_FLAG: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_11
    $past(i_op_valid && (i_op == BAU_OP_ADD || i_op == BAU_OP_SUB)) |-> (o_flags.zero == (o_acc == 8'h00)))
    else $error("zero flag wrong");
  AST_DEC_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_03
    (!i_sys_rst && !(i_op_valid && (i_op == BAU_OP_SET_DEC || i_op == BAU_OP_CLEAR_DEC))) |=>
      $stable(o_flags.decimal))
    else $error("decimal flag changed without its op");
  AST_SET_CARRY: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_16
    (i_op_valid && i_op == BAU_OP_SET_CARRY) |=> o_flags.carry && $stable(o_acc))
    else $error("set carry op failed");
  AST_DEC_ADD: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_01
    (i_op_valid && i_op == BAU_OP_ADD && o_flags.decimal && o_acc == 8'h79 && i_operand == 8'h14
      && !o_flags.carry) |=> (o_acc == 8'h93) && !o_flags.carry)
    else $error("decimal add not corrected");
  AST_DEC_SUB: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_18
    (i_op_valid && i_op == BAU_OP_SUB && o_flags.decimal && o_acc == 8'h44 && i_operand == 8'h29
      && o_flags.carry) |=> (o_acc == 8'h15) && o_flags.carry)
    else $error("decimal subtract not corrected");
  AST_OVF_SUB: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_09
    (i_op_valid && i_op == BAU_OP_SUB && !o_flags.decimal && o_flags.carry && o_acc == 8'h80
      && i_operand == 8'h01) |=> o_flags.ovf ##1 1'b1)
    else $error("subtract overflow missed");
  AST_DONE: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_22
    o_done |-> $past(i_op_valid) && $past(i_op) != BAU_OP_NONE)
    else $error("done without an op");

  // RULE_02 reset leaves binary mode
  AST_RESET_VAL: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_02
    $past(i_sys_rst) |->
      (o_acc == `BAU_RST_ACC) && (o_flags.carry == `BAU_RST_CARRY) && (o_flags.decimal == `BAU_RST_DEC)
      && (o_flags.ovf == `BAU_RST_OVF) && (o_flags.neg == `BAU_RST_NEG) && (o_flags.zero == `BAU_RST_ZERO))
    else $error("state after reset wrong");

  // RULE_02 decimal flag cleared by its op
  AST_CLR_DEC: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_02
    (i_op_valid && i_op == BAU_OP_CLEAR_DEC) |=> !o_flags.decimal && $stable(o_acc))
    else $error("clear decimal op failed");

  // RULE_16 decimal mode set op
  AST_SET_DEC: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_16
    (i_op_valid && i_op == BAU_OP_SET_DEC) |=> o_flags.decimal && $stable(o_flags.carry))
    else $error("set decimal op failed");

  // RULE_16 clear carry op
  AST_CLR_CARRY: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_16
    (i_op_valid && i_op == BAU_OP_CLEAR_CARRY) |=> !o_flags.carry && $stable(o_acc))
    else $error("clear carry op failed");

  // RULE_05 decimal carry above 99
  AST_DEC_CARRY: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_05
    (i_op_valid && i_op == BAU_OP_ADD && o_flags.decimal && o_acc == 8'h99 && i_operand == 8'h01
      && !o_flags.carry) |=> (o_acc == 8'h00) && o_flags.carry)
    else $error("decimal carry above 99 missed");

  // RULE_07 cleared carry borrows one
  AST_BORROW: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_07
    (i_op_valid && i_op == BAU_OP_SUB && !o_flags.decimal && !o_flags.carry && o_acc == 8'h05
      && i_operand == 8'h03) |=> (o_acc == 8'h01) && o_flags.carry)
    else $error("borrow not taken from carry");

  // RULE_19 add overflow from operand signs
  AST_ADD_OVF: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_19
    (i_op_valid && i_op == BAU_OP_ADD && !o_flags.decimal) |=>
      (o_flags.ovf == (($past(o_acc[7]) == $past(i_operand[7])) && (o_acc[7] != $past(o_acc[7])))))
    else $error("add overflow wrong");

  // RULE_09 subtract overflow from operand signs
  AST_SUB_OVF_ALL: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_09
    (i_op_valid && i_op == BAU_OP_SUB && !o_flags.decimal) |=>
      (o_flags.ovf == (($past(o_acc[7]) != $past(i_operand[7])) && (o_acc[7] != $past(o_acc[7])))))
    else $error("subtract overflow wrong");

  // RULE_13 complemented operand into adder
  AST_COMPLEMENT: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_13
    (i_op_valid && i_op == BAU_OP_SUB && !o_flags.decimal) |->
      (res.sum == 8'(o_acc + ~i_operand + 8'(o_flags.carry))))
    else $error("subtract not done by complement");

  // RULE_14 one pass, result in the same cycle
  AST_ONE_PASS: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_14
    (i_op_valid && i_op == BAU_OP_ADD && !o_flags.decimal) |->
      ({res.carry, res.sum} == 9'(o_acc) + 9'(i_operand) + 9'(o_flags.carry)))
    else $error("adder result not ready in one pass");

  // RULE_20 decimal add worth and digits
  AST_DEC_ADD_VAL: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_20
    (i_op_valid && i_op == BAU_OP_ADD && o_flags.decimal && is_bcd(o_acc) && is_bcd(i_operand)) |=>
      (is_bcd(o_acc) && (9'(dec_val(o_acc)) + (o_flags.carry ? 9'h064 : 9'h000) ==
        9'(dec_val($past(o_acc))) + 9'(dec_val($past(i_operand))) + 9'($past(o_flags.carry)))))
    else $error("decimal add digits not corrected");

  // RULE_18 decimal subtract worth and borrow
  AST_DEC_SUB_VAL: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_18
    (i_op_valid && i_op == BAU_OP_SUB && o_flags.decimal && is_bcd(o_acc) && is_bcd(i_operand)) |=>
      (is_bcd(o_acc)
        && (o_flags.carry == (9'(dec_val($past(o_acc))) >=
          9'(dec_val($past(i_operand))) + 9'(!$past(o_flags.carry))))
        && (9'(dec_val(o_acc)) == (o_flags.carry ? 9'h000 : 9'h064) + 9'(dec_val($past(o_acc)))
          - 9'(dec_val($past(i_operand))) - 9'(!$past(o_flags.carry)))))
    else $error("decimal subtract digits not corrected");

  // RULE_15 load keeps carry for next byte
  AST_LOAD: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_15
    (i_op_valid && i_op == BAU_OP_LOAD) |=> (o_acc == $past(i_operand)) && $stable(o_flags.carry))
    else $error("load disturbed carry or missed");

  // RULE_15 carry kept between byte ops
  AST_CARRY_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_15
    (!i_sys_rst && !(i_op_valid && (is_arith(i_op) || i_op == BAU_OP_SET_CARRY
      || i_op == BAU_OP_CLEAR_CARRY))) |=> $stable(o_flags.carry))
    else $error("carry changed without an op");

  // RULE_22 accumulator only moves with an op
  AST_ACC_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_22
    (!i_sys_rst && !(i_op_valid && (is_arith(i_op) || i_op == BAU_OP_LOAD))) |=> $stable(o_acc))
    else $error("accumulator changed without an op");

  // RULE_22 overflow only moves with arithmetic
  AST_OVF_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_22
    (!i_sys_rst && !(i_op_valid && is_arith(i_op))) |=> $stable(o_flags.ovf))
    else $error("overflow changed without arithmetic");

  // RULE_22 done after every taken op
  AST_DONE_PULSE: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_22
    (i_op_valid && i_op != BAU_OP_NONE) |=> o_done)
    else $error("done missing after an op");

  // RULE_22 done lasts one cycle
  AST_DONE_ONE: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_22
    (!i_sys_rst && !i_op_valid) |=> !o_done)
    else $error("done stands too long");

  // RULE_12 no addressing mode refused
  AST_SUB_MODE: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_12
    (i_op_valid && i_op == BAU_OP_SUB) |=> !o_bad_mode)
    else $error("legal addressing mode refused");
endmodule // bau_unit

// [design/bau_consts.svh]
// Purpose: constants for the bcd/binary add-subtract unit
// Assumes: included by bare name
// Notes: flag reset values and widths
`ifndef BAU_CONSTS_SVH
`define BAU_CONSTS_SVH
`define BAU_DATA_W      8
`define BAU_SIGN_BIT    7
`define BAU_NIB_W       4
`define BAU_DIGIT_MAX   4'h9
`define BAU_DIGIT_ADJ   4'h6
`define BAU_RST_ACC     8'h00
`define BAU_RST_CARRY   1'b0
`define BAU_RST_DEC     1'b0
`define BAU_RST_OVF     1'b0
`define BAU_RST_NEG     1'b0
`define BAU_RST_ZERO    1'b1
`define BAU_OP_W        3
`endif

// [design/bau_pkg.sv]
// Purpose: types for the bcd/binary add-subtract unit
// Assumes: bau_consts.svh holds the numbers
// Notes: none
`include "bau_consts.svh"
package bau_pkg;
  // operation requested by the sequencer
  typedef enum logic [`BAU_OP_W-1:0] {
    BAU_OP_NONE,
    BAU_OP_ADD,
    BAU_OP_SUB,
    BAU_OP_SET_CARRY,
    BAU_OP_CLEAR_CARRY,
    BAU_OP_SET_DEC,
    BAU_OP_CLEAR_DEC,
    BAU_OP_LOAD
  } bau_op_type;

  // addressing mode of the operand fetch
  typedef enum logic [2:0] {
    BAU_AM_IMM,
    BAU_AM_ABS,
    BAU_AM_ZP,
    BAU_AM_ABS_X,
    BAU_AM_ABS_Y,
    BAU_AM_ZP_X,
    BAU_AM_IND_X,
    BAU_AM_IND_Y
  } bau_amode_type;

  // processor status bits owned by the unit
  typedef struct packed {
    logic carry;
    logic decimal;
    logic ovf;
    logic neg;
    logic zero;
  } bau_flags_type;

  // result of one byte operation
  typedef struct packed {
    logic [`BAU_DATA_W-1:0] sum;
    logic                   carry;
    logic                   ovf;
  } bau_res_type;

  // whole state of the top module
  typedef struct packed {
    logic [`BAU_DATA_W-1:0] acc;
    bau_flags_type          flags;
    logic                   done;
    logic                   bad_mode;
  } bau_state_type;
endpackage

// [design/bau_adder.sv]
// Purpose: single-pass byte adder with optional bcd correction
// Assumes: operands are valid packed bcd in decimal mode
// Notes: purely combinational
`timescale 1ns/1ps
`include "bau_consts.svh"
module bau_adder
  import bau_pkg::*;
#(
  parameter int DATA_W = `BAU_DATA_W
)
(
  // operands
  input  wire logic [DATA_W-1:0] i_a,
  input  wire logic [DATA_W-1:0] i_m,
  input  wire logic              i_carry,
  // mode
  input  wire logic              i_sub,
  input  wire logic              i_decimal,
  // result
  output bau_res_type            o_res
);
  // elaboration check; the digit split is fixed at two nibbles
  if (DATA_W != 8)
  begin : g_bad_width
    $error("bau_adder serves only 8-bit data");
  end

  // one nibble of the binary add
  function automatic logic [4:0] nib_add(input logic [3:0] a, input logic [3:0] b, input logic c);
    nib_add = {1'b0, a} + {1'b0, b} + {4'h0, c};
  endfunction

  logic [DATA_W-1:0] opnd;
  logic [4:0]        lo_bin;
  logic [4:0]        hi_bin;
  logic [DATA_W:0]   bin_sum;
  logic [3:0]        lo_d;
  logic [3:0]        hi_d;
  logic              lo_c;
  logic              hi_c;
  logic [4:0]        hi_dec;
  logic              ovf;

  // complement and add happen in the same pass
  // RULE_13 complemented operand, shared adder
  assign opnd = i_sub ? ~i_m : i_m;
  // RULE_14 one combined pass
  assign lo_bin  = nib_add(i_a[3:0], opnd[3:0], i_carry);
  assign hi_bin  = nib_add(i_a[7:4], opnd[7:4], lo_bin[4]);
  assign bin_sum = {hi_bin, lo_bin[3:0]};

  // digit correction; add path propagates the adjusted digit carry
  // RULE_20 add or subtract six per digit
  always_comb
  begin
    lo_d   = lo_bin[3:0];
    lo_c   = lo_bin[4];
    hi_dec = 5'h00;
    hi_d   = hi_bin[3:0];
    hi_c   = hi_bin[4];
    if (i_decimal && !i_sub)
    begin
      if (lo_bin > {1'b0, `BAU_DIGIT_MAX})
      begin
        lo_d = lo_bin[3:0] + `BAU_DIGIT_ADJ;
        lo_c = 1'b1;
      end
      hi_dec = nib_add(i_a[7:4], opnd[7:4], lo_c);
      hi_d   = hi_dec[3:0];
      hi_c   = hi_dec[4];
      if (hi_dec > {1'b0, `BAU_DIGIT_MAX})
      begin
        hi_d = hi_dec[3:0] + `BAU_DIGIT_ADJ;
        hi_c = 1'b1;
      end
    end
    else if (i_decimal && i_sub)
    begin
      // RULE_18 decimal borrow correction
      if (!lo_bin[4])
        lo_d = lo_bin[3:0] - `BAU_DIGIT_ADJ;
      if (!hi_bin[4])
        hi_d = hi_bin[3:0] - `BAU_DIGIT_ADJ;
    end
  end

  // overflow from sign of binary result versus operand signs
  // RULE_19 signed overflow
  // RULE_09 overflow on subtract too
  assign ovf   = (i_a[7] == opnd[7]) && (bin_sum[7] != i_a[7]);
  // one driver for the whole result struct
  // RULE_05 carry as ninth bit
  assign o_res = '{sum: {hi_d, lo_d}, carry: hi_c, ovf: ovf};
endmodule // bau_adder

// [bench/bau_seq_model.sv]
// Purpose: sequencer model feeding ops to the add-subtract unit
// Assumes: ops launch just after a rising edge, one per cycle
// Notes: a released operand shows its inverse, never the old byte
`timescale 1ns/1ps
module bau_seq_model
  import bau_pkg::*;
(
  // clock
  input  wire logic     i_clk,
  // op request to the unit
  output logic          o_op_valid,
  output bau_op_type    o_op,
  output bau_amode_type o_amode,
  output logic [7:0]    o_operand
);
  // idle at time zero
  initial
  begin
    o_op_valid = 1'b0;
    o_op = BAU_OP_NONE;
    o_amode = BAU_AM_IMM;
    o_operand = 8'h00;
  end

  task automatic issue(input bau_op_type op, input bau_amode_type am, input logic [7:0] m);
    @(posedge i_clk);
    o_op_valid <= 1'b1;
    o_op <= op;
    o_amode <= am;
    o_operand <= m;
  endtask

  // release; operand must not keep last byte
  task automatic idle();
    @(posedge i_clk);
    o_op_valid <= 1'b0;
    o_op <= BAU_OP_NONE;
    o_operand <= ~o_operand;
  endtask
endmodule // bau_seq_model

// [bench/bau_unit_tb_top.sv]
// Purpose: self-checking bench for the add-subtract unit
// Assumes: latency 1, done pulses after every taken op
// Notes: expectations come from the bench's own reference model
`timescale 1ns/1ps
module bau_unit_tb_top
  import bau_pkg::*;
;
  logic          clk;
  logic          rst;
  logic          op_valid;
  bau_op_type    op;
  bau_amode_type amode;
  logic [7:0]    operand;
  logic [7:0]    acc;
  bau_flags_type flags;
  logic          done;
  logic          bad_mode;
  logic [7:0]    e_acc;
  bau_flags_type e_f;
  bau_op_type    e_last;
  bau_amode_type am;
  int            error_cnt;
  int            tests_run;
  logic [7:0]    aa [7] = '{8'h05, 8'h7f, 8'h05, 8'h05, 8'hfb, 8'hbe, 8'h80};
  logic [7:0]    ma [7] = '{8'h07, 8'h02, 8'hfd, 8'hf9, 8'hf9, 8'hbf, 8'h80};
  logic [7:0]    sa [8] = '{8'h05, 8'h05, 8'h80, 8'h00, 8'h7f, 8'h00, 8'hff, 8'h81};
  logic [7:0]    sm [8] = '{8'h03, 8'h06, 8'h01, 8'h00, 8'hff, 8'h01, 8'hff, 8'h7f};

  // free-running 200 mhz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  bau_seq_model seq (.i_clk(clk), .o_op_valid(op_valid), .o_op(op), .o_amode(amode), .o_operand(operand));

  bau_unit dut (.i_clk(clk), .i_sys_rst(rst), .i_op_valid(op_valid), .i_op(op), .i_amode(amode),
    .i_operand(operand), .o_acc(acc), .o_flags(flags), .o_done(done), .o_bad_mode(bad_mode));

  // reference: returns {acc, flags}
  function automatic logic [12:0] model(bau_op_type o, logic [7:0] a, logic [7:0] m, bau_flags_type f);
    logic [8:0]    b;
    logic [4:0]    lo;
    logic [4:0]    hi;
    logic [7:0]    r;
    logic [7:0]    mm;
    bau_flags_type n;
    n = f;
    r = a;
    if (o == BAU_OP_ADD || o == BAU_OP_SUB)
    begin
      mm = (o == BAU_OP_SUB) ? ~m : m;
      b = {1'b0, a} + {1'b0, mm} + {8'h00, f.carry};
      n.ovf = (a[7] == mm[7]) && (b[7] != a[7]);
      r = b[7:0];
      n.carry = b[8];
      if (f.decimal && o == BAU_OP_ADD)
      begin
        lo = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, f.carry};
        if (lo > 5'h09) lo = lo + 5'h06;
        hi = {1'b0, a[7:4]} + {1'b0, m[7:4]} + {4'h0, lo[4]};
        if (hi > 5'h09) hi = hi + 5'h06;
        r = {hi[3:0], lo[3:0]};
        n.carry = hi[4];
      end
      else if (f.decimal)
      begin
        lo = {1'b0, a[3:0]} + {1'b0, mm[3:0]} + {4'h0, f.carry};
        r[3:0] = lo[4] ? b[3:0] : b[3:0] - 4'h6;
        r[7:4] = b[8] ? b[7:4] : b[7:4] - 4'h6;
      end
    end
    if (o == BAU_OP_LOAD) r = m;
    if (o == BAU_OP_SET_CARRY) n.carry = 1'b1;
    if (o == BAU_OP_CLEAR_CARRY) n.carry = 1'b0;
    if (o == BAU_OP_SET_DEC) n.decimal = 1'b1;
    if (o == BAU_OP_CLEAR_DEC) n.decimal = 1'b0;
    if (o == BAU_OP_ADD || o == BAU_OP_SUB || o == BAU_OP_LOAD)
    begin
      n.neg = r[7];
      n.zero = (r == 8'h00);
    end
    return {r, n};
  endfunction

  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // launch one op back to back, advance the reference
  task automatic run(input bau_op_type o, input logic [7:0] m);
    logic [12:0] r;
    seq.issue(o, am, m);
    r = model(o, e_acc, m, e_f);
    e_acc = r[12:5];
    e_f = bau_flags_type'(r[4:0]);
    e_last = o;
  endtask

  // release and compare once the last edge has landed
  task automatic fin();
    seq.idle();
    #1;
    check({acc, flags, done, bad_mode}, {e_acc, e_f, e_last != BAU_OP_NONE, 1'b0});
  endtask

  // hang guard
  initial
  begin
    #100000;
    error_cnt++;
    give_verdict();
  end

  // main sequence
  initial
  begin
    rst = 1'b1;
    error_cnt = 0;
    tests_run = 0;
    am = BAU_AM_IMM;
    e_acc = 8'h00;
    e_f = 5'h01;
    e_last = BAU_OP_NONE;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check({acc, flags, done, bad_mode}, {8'h00, 5'h01, 2'b00});
    for (int i = 0; i < 7; i++)
    begin
      run(BAU_OP_CLEAR_CARRY, 8'h00);
      run(BAU_OP_LOAD, aa[i]);
      run(BAU_OP_ADD, ma[i]);
      fin();
    end
    for (int i = 0; i < 8; i++)
    begin
      am = bau_amode_type'(i[2:0]);
      run(BAU_OP_SET_CARRY, 8'h00);
      run(BAU_OP_LOAD, sa[i]);
      run(BAU_OP_SUB, sm[i]);
      fin();
    end
    run(BAU_OP_CLEAR_CARRY, 8'h00);
    run(BAU_OP_LOAD, 8'h05);
    run(BAU_OP_SUB, 8'h03);
    fin();
    run(BAU_OP_SET_CARRY, 8'h00);
    run(BAU_OP_LOAD, 8'h00);
    run(BAU_OP_SUB, 8'hff);
    run(BAU_OP_LOAD, 8'h02);
    run(BAU_OP_SUB, 8'h00);
    fin();
    run(BAU_OP_CLEAR_CARRY, 8'h00);
    run(BAU_OP_SET_DEC, 8'h00);
    run(BAU_OP_LOAD, 8'h79);
    run(BAU_OP_ADD, 8'h14);
    fin();
    run(BAU_OP_LOAD, 8'h99);
    run(BAU_OP_ADD, 8'h01);
    fin();
    run(BAU_OP_SET_CARRY, 8'h00);
    run(BAU_OP_LOAD, 8'h44);
    run(BAU_OP_SUB, 8'h29);
    fin();
    run(BAU_OP_SET_CARRY, 8'h00);
    run(BAU_OP_LOAD, 8'h10);
    run(BAU_OP_SUB, 8'h20);
    fin();
    run(BAU_OP_CLEAR_DEC, 8'h00);
    run(BAU_OP_CLEAR_CARRY, 8'h00);
    run(BAU_OP_LOAD, 8'h79);
    run(BAU_OP_ADD, 8'h14);
    fin();
    run(BAU_OP_NONE, 8'h55);
    fin();
    // second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    check({acc, flags, done, bad_mode}, {8'h00, 5'h01, 2'b00});
    // first ops straight after release; reference back to reset values
    e_acc = 8'h00;
    e_f = 5'h01;
    run(BAU_OP_LOAD, 8'h80);
    run(BAU_OP_ADD, 8'h80);
    fin();
    give_verdict();
  end
endmodule // bau_unit_tb_top
